// ---- src/prt_params.svh ----
`ifndef PRT_PARAMS_SVH
`define PRT_PARAMS_SVH

// Register byte offsets on the bus
`define PRT_OFS_CTRL    8'h00
`define PRT_OFS_IOC     8'h04
`define PRT_OFS_MODE    8'h08
`define PRT_OFS_PRE     8'h0c
`define PRT_OFS_TMR     8'h10

// Control register fields
`define PRT_CTRL_START  0
`define PRT_CTRL_STATUS 1
`define PRT_CTRL_STOP   2
`define PRT_CTRL_EDGF   4
`define PRT_CTRL_UNDF   5

// Mode register fields
`define PRT_MODE_LSB    0
`define PRT_SRC_LSB     4

// I/O control register fields
`define PRT_IOC_IO_DATA 0
`define PRT_IOC_IO_DIR  1
`define PRT_IOC_IRQ1_EN 2
`define PRT_IOC_OUT_DAT 3
`define PRT_IOC_OUT_EN  4

// Reset and forced-stop values, clock divider
`define PRT_CNT_RST     8'hff
`define PRT_DIV_HALF    3'h1
`define PRT_DIV_EIGHTH  3'h7

`endif

// ---- src/prt_pkg.sv ----
package prt_pkg;

  typedef enum logic [2:0] {
    MODE_TIMER  = 3'b000,
    MODE_PULSE  = 3'b001,
    MODE_EVENT  = 3'b010,
    MODE_WIDTH  = 3'b011,
    MODE_PERIOD = 3'b100
  } mode_t;

  typedef enum logic [2:0] {
    SRC_UNDIV  = 3'b000,
    SRC_HALF   = 3'b001,
    SRC_EIGHTH = 3'b010,
    SRC_OSC    = 3'b011,
    SRC_SUB32  = 3'b100
  } src_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } aph_t;

endpackage

// ---- src/count_stage.sv ----
`timescale 1ns/100ps
`include "prt_params.svh"
module count_stage #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         tick,
  input  wire logic         wr,
  input  wire logic         running,
  input  wire logic         force_stop,
  input  wire logic [W-1:0] wdata,
  output logic      [W-1:0] count,
  output logic      [W-1:0] reload,
  output logic              unf
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic [W-1:0] rld_ff;
  logic [W-1:0] nxt_rld;
  logic         pend_ff;
  logic         nxt_pend;

  assign count  = cnt_ff;
  assign reload = rld_ff;
  // A pending transfer tick loads the counter and is not an underflow
  assign unf    = running & tick & ~pend_ff & (cnt_ff == '0);

  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_rld  = rld_ff;
    nxt_pend = pend_ff;
    if (force_stop) begin
      nxt_cnt  = W'(`PRT_CNT_RST);
      nxt_rld  = W'(`PRT_CNT_RST);
      nxt_pend = 1'b0;
    end else begin
      if (running && tick) begin
        if (pend_ff) begin
          nxt_cnt  = rld_ff;
          nxt_pend = 1'b0;
        end else if (cnt_ff == '0) begin
          nxt_cnt = rld_ff;
        end else begin
          nxt_cnt = cnt_ff - W'(1);
        end
      end
      if (wr) begin
        nxt_rld = wdata;
        if (running) begin
          nxt_pend = 1'b1;
        end else begin
          nxt_cnt = wdata;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_ff  <= W'(`PRT_CNT_RST);
      rld_ff  <= W'(`PRT_CNT_RST);
      pend_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      rld_ff  <= nxt_rld;
      pend_ff <= nxt_pend;
    end
  end

endmodule

// ---- src/prescaled_reload_timer.sv ----
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "prt_params.svh"
module prescaled_reload_timer import prt_pkg::*; #(
  parameter bit HAS_SUBCLK = 1'b1
) (
  input  wire logic        MCLK,
  input  wire logic        NRST,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        ONCHIP_OSC_CLK,
  input  wire logic        SUBCLK_DIV32,
  input  wire logic        TIMER_IO_IN,
  output logic             TIMER_IO_OUT,
  output logic             TIMER_IO_OE,
  output logic             TIMER_OUT_OUT,
  output logic             TIMER_OUT_OE,
  output logic             EXT_IRQ1,
  output logic             TIMER_IRQ
);

  aph_t        aph_ff;
  aph_t        nxt_aph;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        rdy_ff;
  logic        start_ff;
  logic        nxt_start;
  logic        status_ff;
  logic        nxt_status;
  logic        edgf_ff;
  logic        nxt_edgf;
  logic        undf_ff;
  logic        nxt_undf;
  logic [2:0]  mode_ff;
  logic [2:0]  nxt_mode;
  logic [2:0]  src_ff;
  logic [2:0]  nxt_src;
  logic [4:0]  ioc_ff;
  logic [4:0]  nxt_ioc;
  logic [2:0]  div_ff;
  logic [2:0]  syn1_ff;
  logic [2:0]  syn2_ff;
  logic [2:0]  syn3_ff;
  logic [2:0]  lvl_ff;
  logic [2:0]  nxt_lvl;
  logic        irq_ff;
  logic        irq1_ff;
  logic        io_out_ff;
  logic        io_oe_ff;
  logic        out_out_ff;
  logic        out_oe_ff;
  logic        wr_go;
  logic        rd_go;
  logic        wr_ctrl;
  logic        force_stop;
  logic        src_tick;
  logic        osc_rise;
  logic        sub_rise;
  logic [7:0]  pre_cnt;
  logic [7:0]  pre_rld;
  logic [7:0]  tmr_cnt;
  logic [7:0]  tmr_rld;
  logic        pre_unf;
  logic        tmr_unf;

  assign HRDATA        = rdata_ff;
  assign HREADYOUT     = rdy_ff;
  assign HRESP         = 1'b0;
  assign TIMER_IRQ     = irq_ff;
  assign EXT_IRQ1      = irq1_ff;
  assign TIMER_IO_OUT  = io_out_ff;
  assign TIMER_IO_OE   = io_oe_ff;
  assign TIMER_OUT_OUT = out_out_ff;
  assign TIMER_OUT_OE  = out_oe_ff;

  // Bus slave: zero wait states, write lands at the end of its data phase
  assign wr_go   = aph_ff.valid & aph_ff.write;
  assign rd_go   = HSEL & HTRANS[1] & ~HWRITE & HREADY;
  assign wr_ctrl = wr_go & (aph_ff.addr == `PRT_OFS_CTRL);
  assign force_stop = wr_ctrl & HWDATA[`PRT_CTRL_STOP];

  function automatic logic [31:0] read_mux(input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0;
    unique case (a)
      `PRT_OFS_CTRL: begin
        d[`PRT_CTRL_START]  = start_ff;
        d[`PRT_CTRL_STATUS] = status_ff;
        d[`PRT_CTRL_EDGF]   = edgf_ff;
        d[`PRT_CTRL_UNDF]   = undf_ff;
      end
      `PRT_OFS_IOC:  d[4:0] = ioc_ff;
      `PRT_OFS_MODE: begin
        d[`PRT_MODE_LSB +: 3] = mode_ff;
        d[`PRT_SRC_LSB +: 3]  = src_ff;
      end
      `PRT_OFS_PRE:  d[7:0] = pre_cnt;
      `PRT_OFS_TMR:  d[7:0] = tmr_cnt;
      default:       d = 32'h0;
    endcase
    return d;
  endfunction

  always_comb begin
    nxt_aph = aph_ff;
    if (HREADY) begin
      nxt_aph.valid = HSEL & HTRANS[1];
      nxt_aph.write = HWRITE;
      nxt_aph.addr  = {HADDR[7:2], 2'b00};
    end
    nxt_rdata = rd_go ? read_mux({HADDR[7:2], 2'b00}) : rdata_ff;
  end

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      aph_ff   <= '0;
      rdata_ff <= 32'h0;
      rdy_ff   <= 1'b1;
    end else begin
      aph_ff   <= nxt_aph;
      rdata_ff <= nxt_rdata;
      rdy_ff   <= 1'b1;
    end
  end

  // Pins from other clocks: three flops, a level counts once stages two and three agree
  always_comb begin
    nxt_lvl = lvl_ff;
    for (int i = 0; i < 3; i++) begin
      if (syn2_ff[i] == syn3_ff[i]) begin
        nxt_lvl[i] = syn3_ff[i];
      end
    end
  end

  assign osc_rise = nxt_lvl[0] & ~lvl_ff[0];
  assign sub_rise = nxt_lvl[1] & ~lvl_ff[1];

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      syn1_ff <= 3'h0;
      syn2_ff <= 3'h0;
      syn3_ff <= 3'h0;
      lvl_ff  <= 3'h0;
      div_ff  <= 3'h0;
    end else begin
      syn1_ff <= {TIMER_IO_IN, SUBCLK_DIV32, ONCHIP_OSC_CLK};
      syn2_ff <= syn1_ff;
      syn3_ff <= syn2_ff;
      lvl_ff  <= nxt_lvl;
      div_ff  <= div_ff + 3'h1;
    end
  end

  // Count source select; unused codes give no ticks
  always_comb begin
    unique case (src_ff)
      SRC_UNDIV:  src_tick = 1'b1;
      SRC_HALF:   src_tick = ({2'b00, div_ff[0]} == `PRT_DIV_HALF);
      SRC_EIGHTH: src_tick = (div_ff == `PRT_DIV_EIGHTH);
      SRC_OSC:    src_tick = osc_rise;
      SRC_SUB32:  src_tick = HAS_SUBCLK & sub_rise;
      default:    src_tick = 1'b0;
    endcase
  end

  // Control, mode and I/O registers
  always_comb begin
    nxt_start  = start_ff;
    nxt_status = status_ff;
    nxt_edgf   = edgf_ff;
    nxt_undf   = undf_ff;
    nxt_mode   = mode_ff;
    nxt_src    = src_ff;
    nxt_ioc    = ioc_ff;
    if (force_stop) begin
      nxt_start  = 1'b0;
      nxt_status = 1'b0;
    end else begin
      if (wr_ctrl) begin
        nxt_start = HWDATA[`PRT_CTRL_START];
      end
      if (src_tick) begin
        nxt_status = start_ff;
      end
    end
    if (wr_ctrl && !HWDATA[`PRT_CTRL_EDGF]) begin
      nxt_edgf = 1'b0;
    end
    if (wr_ctrl && !HWDATA[`PRT_CTRL_UNDF]) begin
      nxt_undf = 1'b0;
    end
    // A new underflow beats a clear in the same cycle
    if (tmr_unf) begin
      nxt_undf = 1'b1;
    end
    if (wr_go && aph_ff.addr == `PRT_OFS_MODE) begin
      nxt_mode = HWDATA[`PRT_MODE_LSB +: 3];
      nxt_src  = HWDATA[`PRT_SRC_LSB +: 3];
    end
    // Guarding this write is left to software, which waits for start and status low
    if (wr_go && aph_ff.addr == `PRT_OFS_IOC) begin
      nxt_ioc = HWDATA[4:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      start_ff   <= 1'b0;
      status_ff  <= 1'b0;
      edgf_ff    <= 1'b0;
      undf_ff    <= 1'b0;
      mode_ff    <= MODE_TIMER;
      src_ff     <= SRC_UNDIV;
      ioc_ff     <= 5'h0;
      irq_ff     <= 1'b0;
      irq1_ff    <= 1'b0;
      io_out_ff  <= 1'b0;
      io_oe_ff   <= 1'b0;
      out_out_ff <= 1'b0;
      out_oe_ff  <= 1'b0;
    end else begin
      start_ff   <= nxt_start;
      status_ff  <= nxt_status;
      edgf_ff    <= nxt_edgf;
      undf_ff    <= nxt_undf;
      mode_ff    <= nxt_mode;
      src_ff     <= nxt_src;
      ioc_ff     <= nxt_ioc;
      irq_ff     <= tmr_unf;
      irq1_ff    <= lvl_ff[2] & ioc_ff[`PRT_IOC_IRQ1_EN];
      io_out_ff  <= ioc_ff[`PRT_IOC_IO_DATA];
      io_oe_ff   <= ioc_ff[`PRT_IOC_IO_DIR];
      out_out_ff <= ioc_ff[`PRT_IOC_OUT_DAT];
      out_oe_ff  <= ioc_ff[`PRT_IOC_OUT_EN];
    end
  end

  // Prescaler counts source ticks; timer counts prescaler underflows
  count_stage #(.W(8)) u_pre (
    .clk        (MCLK),
    .rst_n      (NRST),
    .tick       (src_tick),
    .wr         (wr_go && aph_ff.addr == `PRT_OFS_PRE),
    .running    (status_ff),
    .force_stop (force_stop),
    .wdata      (HWDATA[7:0]),
    .count      (pre_cnt),
    .reload     (pre_rld),
    .unf        (pre_unf)
  );

  count_stage #(.W(8)) u_tmr (
    .clk        (MCLK),
    .rst_n      (NRST),
    .tick       (pre_unf),
    .wr         (wr_go && aph_ff.addr == `PRT_OFS_TMR),
    .running    (status_ff),
    .force_stop (force_stop),
    .wdata      (HWDATA[7:0]),
    .count      (tmr_cnt),
    .reload     (tmr_rld),
    .unf        (tmr_unf)
  );

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);

  force_stop_a: assert property (force_stop |=> !start_ff && !status_ff)
    else $error("Forced stop left the timer running");
  stop_values_a: assert property (force_stop |=> pre_cnt == 8'hff && tmr_cnt == 8'hff
                                  && pre_rld == 8'hff && tmr_rld == 8'hff)
    else $error("Forced stop did not load all ones");
  start_bit_a: assert property (wr_ctrl && HWDATA[0] && !HWDATA[2] |=> start_ff)
    else $error("Start write did not set start");
  stop_bit_a: assert property (wr_ctrl && !HWDATA[0] |=> !start_ff)
    else $error("Stop write did not clear start");
  undf_keep_a: assert property (undf_ff && !(wr_ctrl && !HWDATA[5]) |=> undf_ff)
    else $error("Underflow flag dropped without a zero write");
  irq_pulse_a: assert property (tmr_unf |=> TIMER_IRQ && undf_ff)
    else $error("Underflow did not raise the request and the flag");
  read_live_a: assert property (rd_go && HADDR[7:0] == 8'h0c |=> HRDATA[7:0] == $past(pre_cnt))
    else $error("Prescaler read did not return the live count");
  stopped_write_a: assert property (wr_go && aph_ff.addr == 8'h10 && !status_ff && !force_stop
                                    |=> tmr_cnt == $past(HWDATA[7:0]))
    else $error("Write while stopped missed the counter");
  reload_run_a: assert property (tmr_unf && !wr_go |=> tmr_cnt == $past(tmr_rld))
    else $error("Timer did not reload on underflow");
  status_src_a: assert property ($rose(status_ff) |-> $past(start_ff) && $past(src_tick))
    else $error("Status rose without start and a source tick");

endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/100ps
`include "prt_params.svh"
module tb_top;
  logic        MCLK, NRST, HSEL, HWRITE, ONCHIP_OSC_CLK, SUBCLK_DIV32, TIMER_IO_IN;
  logic [1:0]  HTRANS;
  logic [31:0] HADDR, HWDATA, HRDATA, rd;
  logic        HREADYOUT, HRESP, TIMER_IO_OUT, TIMER_IO_OE, TIMER_OUT_OUT, TIMER_OUT_OE, EXT_IRQ1, TIMER_IRQ;
  int          fail_count, total_checks, s, n, m, v, t1, t2;
  int          cyc = 0;
  // MCLK cycles per source tick: the bench toggles osc every 3 and subclock every 5 cycles
  int          dv[5] = '{1, 2, 8, 6, 10};

  prescaled_reload_timer dut (
    .MCLK(MCLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .ONCHIP_OSC_CLK(ONCHIP_OSC_CLK), .SUBCLK_DIV32(SUBCLK_DIV32),
    .TIMER_IO_IN(TIMER_IO_IN), .TIMER_IO_OUT(TIMER_IO_OUT), .TIMER_IO_OE(TIMER_IO_OE),
    .TIMER_OUT_OUT(TIMER_OUT_OUT), .TIMER_OUT_OE(TIMER_OUT_OE), .EXT_IRQ1(EXT_IRQ1),
    .TIMER_IRQ(TIMER_IRQ)
  );

  initial begin
    MCLK = 1'b0;
    forever #25 MCLK = ~MCLK;
  end

  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    ONCHIP_OSC_CLK <= (cyc % 6) < 3;
    SUBCLK_DIV32 <= (cyc % 10) < 5;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {24'h0, a};
    HWRITE <= wr;
    @(posedge MCLK);
    while (HREADYOUT !== 1'b1) @(posedge MCLK);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    @(posedge MCLK);
    while (HREADYOUT !== 1'b1) @(posedge MCLK);
    rd = HRDATA;
    // An idle cycle after a write keeps the next read clear of the write hazard
    if (wr) @(posedge MCLK);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({HREADYOUT, HRESP}, 32'h2);
  endtask

  task automatic wait_irq(output int t);
    int k;
    k = 0;
    do begin
      @(posedge MCLK);
      k++;
    end while (TIMER_IRQ !== 1'b1 && k < 400);
    t = cyc;
  endtask

  task automatic quiet;
    int c;
    c = 0;
    repeat (40) begin
      @(posedge MCLK);
      if (TIMER_IRQ !== 1'b0) c++;
    end
    chk(c, 0);
  endtask

  task end_of_test;
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #(50 * 40000);
    fail_count++;
    end_of_test;
  end

  initial begin
    fail_count = 0;
    total_checks = 0;
    NRST = 1'b0;
    HSEL = 1'b0;
    HTRANS = 2'h0;
    HADDR = 32'h0;
    HWRITE = 1'b0;
    HWDATA = 32'h0;
    TIMER_IO_IN = 1'b0;
    ONCHIP_OSC_CLK = 1'b0;
    SUBCLK_DIV32 = 1'b0;
    void'($urandom(63244));
    repeat (20) @(posedge MCLK);
    NRST <= 1'b1;
    @(posedge MCLK);
    rdchk(`PRT_OFS_CTRL, 32'h0);
    rdchk(`PRT_OFS_PRE, 32'hff);
    rdchk(`PRT_OFS_TMR, 32'hff);
    wr(8'h14, 32'hffffffff);
    rdchk(8'h14, 32'h0);
    for (s = 0; s < 5; s++) begin
      n = $urandom % 4;
      m = $urandom % 4;
      wr(`PRT_OFS_MODE, s << 4);
      wr(`PRT_OFS_PRE, n);
      wr(`PRT_OFS_TMR, m);
      rdchk(`PRT_OFS_PRE, n);
      rdchk(`PRT_OFS_TMR, m);
      wr(`PRT_OFS_CTRL, 32'h1);
      wait_irq(t1);
      wait_irq(t2);
      chk(t2 - t1, (n + 1) * (m + 1) * dv[s]);
      rdchk(`PRT_OFS_CTRL, 32'h23);
      wr(`PRT_OFS_CTRL, 32'h24);
      rdchk(`PRT_OFS_CTRL, 32'h20);
      rdchk(`PRT_OFS_PRE, 32'hff);
      rdchk(`PRT_OFS_TMR, 32'hff);
      quiet;
      wr(`PRT_OFS_CTRL, 32'h0);
      rdchk(`PRT_OFS_CTRL, 32'h0);
    end
    wr(`PRT_OFS_MODE, 32'h0);
    wr(`PRT_OFS_PRE, 32'h0);
    wr(`PRT_OFS_TMR, 32'h1);
    wr(`PRT_OFS_CTRL, 32'h1);
    wait_irq(t1);
    wr(`PRT_OFS_TMR, 32'h3);
    // The first period after the rewrite may be partial, so skip it
    wait_irq(t1);
    wait_irq(t1);
    wait_irq(t2);
    chk(t2 - t1, 4);
    wr(`PRT_OFS_CTRL, 32'h20);
    repeat (3) @(posedge MCLK);
    rdchk(`PRT_OFS_CTRL, 32'h20);
    quiet;
    for (s = 0; s < 5; s++) begin
      wr(`PRT_OFS_MODE, s);
      rdchk(`PRT_OFS_MODE, s);
      v = $urandom % 32;
      TIMER_IO_IN <= 1'($urandom % 2);
      wr(`PRT_OFS_IOC, v);
      repeat (6) @(posedge MCLK);
      rdchk(`PRT_OFS_IOC, v);
      chk({EXT_IRQ1, TIMER_OUT_OE, TIMER_OUT_OUT, TIMER_IO_OE, TIMER_IO_OUT},
          {TIMER_IO_IN & v[2], v[4], v[3], v[1], v[0]});
    end
    // A source code with no ticks: start holds, status never follows
    wr(`PRT_OFS_MODE, 32'h50);
    wr(`PRT_OFS_CTRL, 32'h21);
    repeat (20) @(posedge MCLK);
    rdchk(`PRT_OFS_CTRL, 32'h21);
    wr(`PRT_OFS_CTRL, 32'h4);
    rdchk(`PRT_OFS_CTRL, 32'h0);
    end_of_test;
  end
endmodule
